// ===== core/lbcs_pkg.sv
// Purpose: Shared constants and carriers for the local bus control and region selects.
// Assumes: One 100 MHz clock; all inputs synchronous to it.
// Notes:   Region windows are kept as base and mask pairs on a 20-bit address.
package lbcs_pkg;

  localparam int unsigned ADDR_W     = 20;
  localparam int unsigned GEN_CNT    = 8;
  localparam int unsigned REGION_CNT = 10;

  // Upper region window after reset, 0FFC00H through 0FFFFFH.
  localparam logic [19:0] UPPER_RST_BASE = 20'hFFC00;
  localparam logic [19:0] UPPER_RST_MASK = 20'hFFC00;
  localparam logic [19:0] ZERO_ADDR      = 20'h00000;

  // Region indices inside the window table.
  localparam int unsigned REG_UPPER = 0;
  localparam int unsigned REG_LOWER = 1;
  localparam int unsigned REG_GEN0  = 2;

  // Interrupt type raised on a coprocessor error.
  localparam logic [7:0] COPROC_ERR_TYPE = 8'h10;

  // Kinds of bus cycle.
  typedef enum logic [2:0] {
    LBCS_CYC_MEM_RD = 3'h0,
    LBCS_CYC_MEM_WR = 3'h1,
    LBCS_CYC_IO_RD  = 3'h2,
    LBCS_CYC_IO_WR  = 3'h3,
    LBCS_CYC_FETCH  = 3'h4,
    LBCS_CYC_REFRESH = 3'h5,
    LBCS_CYC_COPROC = 3'h6
  } lbcs_cyc_t;

  // Bus sequencer states, one-hot.
  typedef enum logic [4:0] {
    LBCS_IDLE = 5'h01,
    LBCS_ADDR = 5'h02,
    LBCS_DATA = 5'h04,
    LBCS_DONE = 5'h08,
    LBCS_HELD = 5'h10
  } lbcs_state_t;

  // One bus request from the core.
  typedef struct packed {
    lbcs_cyc_t         kind;
    logic [19:0]       addr;
    logic              byte_high;
    logic              locked;
    logic              boundary;
    logic [15:0]       wdata;
  } lbcs_req_t;

  // One region window programming write.
  typedef struct packed {
    logic              valid;
    logic [3:0]        index;
    logic [19:0]       base;
    logic [19:0]       mask;
    logic              enable;
    logic              mem_only;
    logic              no_ready;
  } lbcs_win_t;

  // True when a cycle kind is a memory cycle.
  function automatic logic lbcs_is_mem(input lbcs_cyc_t k);
    return (k == LBCS_CYC_MEM_RD) || (k == LBCS_CYC_MEM_WR) ||
           (k == LBCS_CYC_FETCH)  || (k == LBCS_CYC_REFRESH);
  endfunction : lbcs_is_mem

  // True when a cycle kind reads from the bus.
  function automatic logic lbcs_is_read(input lbcs_cyc_t k);
    return (k == LBCS_CYC_MEM_RD) || (k == LBCS_CYC_IO_RD) ||
           (k == LBCS_CYC_FETCH)  || (k == LBCS_CYC_REFRESH);
  endfunction : lbcs_is_read

endpackage : lbcs_pkg

// ===== core/lbcs_port.sv
// Purpose: Output port latch for one generic select pin and its read-back.
// Assumes: Writes come from the core as one-cycle strobes.
// Notes:   Read-back samples the driven pin level, not the latch.
`timescale 1ns/100ps
`default_nettype none
module lbcs_port (
  input  wire logic ref_clk_i,
  input  wire logic reset_n_i,
  input  wire logic clk_en_i,
  input  wire logic wr_i,
  input  wire logic wdata_i,
  input  wire logic pin_level_i,
  output logic      latch_o,
  output logic      readback_o
);
  import lbcs_pkg::*;

  logic latch_q;
  logic rb_q;

  // Port latch resets high so the pin idles inactive.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      latch_q <= 1'b1;
      rb_q    <= 1'b1;
    end else if (clk_en_i) begin
      if (wr_i) begin
        latch_q <= wdata_i;
      end
      rb_q <= pin_level_i;
    end
  end

  assign latch_o    = latch_q;
  assign readback_o = rb_q;

endmodule : lbcs_port
`default_nettype wire

// ===== core/lbcs_top.sv
// Purpose: Local bus control, hold handover, coprocessor handshake and region selects.
// Assumes: Core requests arrive as a valid/ready pair; inputs synchronous to ref_clk_i.
// Notes:   One bus cycle is ADDR, then DATA until ready, then DONE.
// Behaviour
// - Narrow variant drives refresh strobe low during refresh cycles.
// - Read strobe asks addressed device to drive the data bus.
// - Write strobe asserted while write data is valid on the bus.
// - Cycle ends only after ready, unless the region ignores ready.
// - Transceiver enable active only while data moves on the bus.
// - Transceiver direction chooses buffer drive toward or away from processor.
// - No bus grant while lock output is active.
// - During external reset the lock pin is a weakly held high input.
// - Hold is granted only at an unlocked instruction boundary.
// - With bus grant out, data bus and controls are floated.
// - Wide variant asserts coprocessor select on coprocessor accesses.
// - Wide variant raises interrupt type 16 on a coprocessor error at numerics start.
// - Upper select active for cycles within its programmed range.
// - After reset upper select covers memory 0FFC00H to 0FFFFFH.
// - Lower select active only for memory cycles in its range.
// - Lower select inactive after reset until programmed.
// - Generic selects match their range when enabled, else act as port pins.
// - Port-mode generic pins can be read back internally.
// - Address latch strobe pulses in each cycle's address phase.
// - Upper address lines 16 to 19 are zero in the data phase.
`timescale 1ns/100ps
`default_nettype none
module lbcs_top #(
  parameter bit WIDE_BUS = 1'b1
) (
  input  wire logic                ref_clk_i,
  input  wire logic                reset_n_i,
  input  wire logic                clk_en_i,
  input  wire logic                external_reset_in_n_i,
  input  wire lbcs_pkg::lbcs_req_t req_i,
  input  wire logic                req_valid_i,
  output logic                     req_ready_o,
  output logic                     done_o,
  output logic [15:0]              rdata_o,
  input  wire lbcs_pkg::lbcs_win_t win_i,
  input  wire logic [7:0]          port_wr_i,
  input  wire logic [7:0]          port_wdata_i,
  output logic [7:0]               port_readback_o,
  input  wire logic                ready_i,
  input  wire logic                hold_i,
  input  wire logic                coproc_error_i,
  input  wire logic                coproc_transfer_request_i,
  output logic                     coproc_pending_o,
  output logic                     irq_valid_o,
  output logic [7:0]               irq_type_o,
  input  wire logic [15:0]         ad_i,
  output logic [15:0]              ad_o,
  output logic                     ad_oe_o,
  output logic [3:0]               addr_hi_o,
  output logic                     addr_hi_oe_o,
  output logic                     addr_latch_o,
  output logic                     read_strobe_n_o,
  output logic                     write_strobe_n_o,
  output logic                     ctrl_oe_o,
  output logic                     high_byte_enable_n_o,
  output logic                     refresh_strobe_n_o,
  output logic                     transceiver_enable_n_o,
  output logic                     transceiver_direction_o,
  output logic                     lock_n_o,
  output logic                     lock_oe_o,
  output logic                     lock_pullup_o,
  output logic                     bus_grant_out_o,
  output logic                     coproc_select_n_o,
  output logic                     upper_region_select_n_o,
  output logic                     lower_region_select_n_o,
  output logic [7:0]               generic_region_select_n_o
);
  import lbcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and request capture.

  lbcs_state_t state_q;
  lbcs_state_t state_d;
  lbcs_req_t   req_q;
  logic [15:0] rdata_q;
  logic        lock_q;
  logic        grant_q;
  logic        irq_q;
  logic [7:0]  irq_type_q;

  wire in_idle  = (state_q == LBCS_IDLE);
  wire in_addr  = (state_q == LBCS_ADDR);
  wire in_data  = (state_q == LBCS_DATA);
  wire in_done  = (state_q == LBCS_DONE);
  wire in_held  = (state_q == LBCS_HELD);
  wire in_cycle = in_addr || in_data;
  wire cyc_mem  = lbcs_is_mem(req_q.kind);
  wire cyc_rd   = lbcs_is_read(req_q.kind);
  wire cyc_refresh = (req_q.kind == LBCS_CYC_REFRESH);
  wire cyc_cop  = (req_q.kind == LBCS_CYC_COPROC);
  wire rst_ext  = !external_reset_in_n_i;

  // Hold wins only at an unlocked instruction boundary in idle.
  wire grant_ok  = hold_i && !lock_q && (!req_valid_i || req_i.boundary);
  wire take_req  = in_idle && req_valid_i && !hold_i;
  wire take_hold = in_idle && grant_ok && !rst_ext;

  ////////////////////////////////////////////////////////////////////////////
  // Region windows: upper, lower, eight generic.

  logic [REGION_CNT-1:0] match_w;
  logic [REGION_CNT-1:0] en_w;
  logic [REGION_CNT-1:0] nrdy_w;
  logic [REGION_CNT-1:0] prog_w;

  genvar gi;
  generate
    for (gi = 0; gi < REGION_CNT; gi++) begin : g_win
      assign prog_w[gi] = win_i.valid && (win_i.index == 4'(gi));
      lbcs_window u_win (
        .ref_clk_i      (ref_clk_i),
        .reset_n_i      (reset_n_i),
        .clk_en_i       (clk_en_i),
        .rst_enable_i   (gi == REG_UPPER),
        .rst_base_i     (UPPER_RST_BASE),
        .rst_mask_i     (UPPER_RST_MASK),
        .rst_mem_only_i (1'b1),
        .prog_i         (prog_w[gi]),
        .win_i          (win_i),
        .cycle_i        (take_req || (in_cycle && !cyc_cop)),
        .is_mem_i       (take_req ? lbcs_is_mem(req_i.kind) : cyc_mem),
        .addr_i         (take_req ? req_i.addr : req_q.addr),
        .match_o        (match_w[gi]),
        .enable_o       (en_w[gi]),
        .no_ready_o     (nrdy_w[gi])
      );
    end
  endgenerate

  // Ready is waived when the matching region says so.
  wire ready_waived = |(match_w & nrdy_w);
  wire cycle_end    = in_data && (ready_i || ready_waived);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      LBCS_IDLE: begin
        if (take_hold) state_d = LBCS_HELD;
        else if (take_req) state_d = LBCS_ADDR;
      end
      LBCS_ADDR: state_d = LBCS_DATA;
      LBCS_DATA: if (cycle_end) state_d = LBCS_DONE;
      LBCS_DONE: state_d = LBCS_IDLE;
      LBCS_HELD: if (!hold_i) state_d = LBCS_IDLE;
      default:   state_d = LBCS_IDLE;
    endcase
  end

  // State, request, lock, grant and read data registers.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q    <= LBCS_IDLE;
      req_q      <= '0;
      rdata_q    <= 16'h0000;
      lock_q     <= 1'b0;
      grant_q    <= 1'b0;
      irq_q      <= 1'b0;
      irq_type_q <= 8'h00;
    end else if (clk_en_i) begin
      state_q <= rst_ext ? LBCS_IDLE : state_d;
      irq_q   <= 1'b0;
      if (take_req) begin
        req_q  <= req_i;
        lock_q <= req_i.locked;
        // Error sampled at the start of a numerics operation.
        if (WIDE_BUS && req_i.kind == LBCS_CYC_COPROC && coproc_error_i) begin
          irq_q      <= 1'b1;
          irq_type_q <= COPROC_ERR_TYPE;
        end
      end else if (in_idle && req_i.boundary && !req_valid_i) begin
        lock_q <= 1'b0;
      end
      if (cycle_end && cyc_rd) rdata_q <= ad_i;
      grant_q <= (state_d == LBCS_HELD) && !rst_ext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus pins.

  wire float_bus = grant_q || in_held || rst_ext;
  assign ctrl_oe_o    = !float_bus;
  assign addr_latch_o = in_addr;
  assign ad_o         = in_addr ? req_q.addr[15:0] : req_q.wdata;
  assign ad_oe_o      = !float_bus && (in_addr || (in_data && !cyc_rd));
  assign addr_hi_o    = in_addr ? req_q.addr[19:16] : 4'h0;
  assign addr_hi_oe_o = !float_bus;

  // Strobes only in the data phase.
  assign read_strobe_n_o  = !(in_data && cyc_rd && !cyc_refresh);
  assign write_strobe_n_o = !(in_data && !cyc_rd);
  assign transceiver_enable_n_o  = !(in_data && !float_bus);
  assign transceiver_direction_o = !(in_cycle && cyc_rd);

  // Refresh strobe on the narrow variant, byte enable on the wide one.
  assign refresh_strobe_n_o   = WIDE_BUS ? 1'b1 : !(in_cycle && cyc_refresh);
  assign high_byte_enable_n_o = WIDE_BUS ? !(in_cycle && req_q.byte_high) : 1'b1;

  // Lock pin becomes a weakly held input during reset.
  assign lock_n_o      = !(lock_q && in_cycle);
  assign lock_oe_o     = !rst_ext && !float_bus;
  assign lock_pullup_o = rst_ext;

  assign bus_grant_out_o   = grant_q;
  assign coproc_select_n_o = !(WIDE_BUS && in_cycle && cyc_cop);
  assign coproc_pending_o  = WIDE_BUS && coproc_transfer_request_i;

  ////////////////////////////////////////////////////////////////////////////
  // Region selects and generic port pins.

  logic [7:0] latch_w;
  logic [7:0] gen_sel_w;
  assign upper_region_select_n_o = !(match_w[REG_UPPER] && in_cycle);
  assign lower_region_select_n_o = !(match_w[REG_LOWER] && in_cycle);

  generate
    for (gi = 0; gi < GEN_CNT; gi++) begin : g_gen
      assign gen_sel_w[gi] = en_w[REG_GEN0+gi] ? !(match_w[REG_GEN0+gi] && in_cycle)
                                                : latch_w[gi];
      lbcs_port u_port (
        .ref_clk_i   (ref_clk_i),
        .reset_n_i   (reset_n_i),
        .clk_en_i    (clk_en_i),
        .wr_i        (port_wr_i[gi]),
        .wdata_i     (port_wdata_i[gi]),
        .pin_level_i (gen_sel_w[gi]),
        .latch_o     (latch_w[gi]),
        .readback_o  (port_readback_o[gi])
      );
    end
  endgenerate

  assign generic_region_select_n_o = gen_sel_w;

  assign req_ready_o = take_req;
  assign done_o      = in_done;
  assign rdata_o     = rdata_q;
  assign irq_valid_o = irq_q;
  assign irq_type_o  = irq_type_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_no_grant_lock: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    lock_q |-> !bus_grant_out_o) else $error("grant while locked");
  a_ready_ends: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    clk_en_i && external_reset_in_n_i && in_data && !ready_i && !ready_waived |=> in_data)
    else $error("early end");
  a_ale_addr: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    addr_latch_o |=> !addr_latch_o) else $error("latch strobe stuck");
  a_hi_zero: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    in_data |-> addr_hi_o == 4'h0) else $error("high address in data");
  a_float_grant: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    bus_grant_out_o |-> !ad_oe_o && !ctrl_oe_o) else $error("bus driven in grant");
  a_lock_reset: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !external_reset_in_n_i |-> !lock_oe_o && lock_pullup_o) else $error("lock driven");
  a_den_data: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !transceiver_enable_n_o |-> in_data) else $error("enable outside data");
  a_wr_data: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !write_strobe_n_o |-> ad_oe_o) else $error("write without data");
  a_sel_idle: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    in_idle |-> upper_region_select_n_o && lower_region_select_n_o) else $error("select idle");
  a_err_irq: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    irq_valid_o |-> irq_type_o == 8'h10) else $error("irq type");

endmodule : lbcs_top
`default_nettype wire

// ===== core/lbcs_window.sv
// Purpose: One programmable address window producing a registered match.
// Assumes: Programming and address change only at cycle starts.
// Notes:   Match is registered so the select is glitch-free.
`timescale 1ns/100ps
`default_nettype none
module lbcs_window (
  input  wire logic                  ref_clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  clk_en_i,
  input  wire logic                  rst_enable_i,
  input  wire logic [19:0]           rst_base_i,
  input  wire logic [19:0]           rst_mask_i,
  input  wire logic                  rst_mem_only_i,
  input  wire logic                  prog_i,
  input  wire lbcs_pkg::lbcs_win_t   win_i,
  input  wire logic                  cycle_i,
  input  wire logic                  is_mem_i,
  input  wire logic [19:0]           addr_i,
  output logic                       match_o,
  output logic                       enable_o,
  output logic                       no_ready_o
);
  import lbcs_pkg::*;

  logic [19:0] base_q;
  logic [19:0] mask_q;
  logic        en_q;
  logic        memo_q;
  logic        nrdy_q;
  logic        match_q;
  logic        hit_d;

  // Address compare against the programmed window.
  assign hit_d = en_q && cycle_i && ((addr_i & mask_q) == (base_q & mask_q))
                 && (is_mem_i || !memo_q);

  // Window storage, cleared at reset; the upper window loads its strap-free constants on the next enabled clock.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      base_q  <= ZERO_ADDR;
      mask_q  <= ZERO_ADDR;
      en_q    <= 1'b0;
      memo_q  <= 1'b1;
      nrdy_q  <= 1'b0;
      match_q <= 1'b0;
    end else if (clk_en_i) begin
      if (prog_i) begin
        base_q <= win_i.base;
        mask_q <= win_i.mask;
        en_q   <= win_i.enable;
        memo_q <= win_i.mem_only;
        nrdy_q <= win_i.no_ready;
      end else if (!en_q && rst_enable_i && mask_q == ZERO_ADDR && !nrdy_q) begin
        // First enabled cycle after reset loads the default window.
        base_q <= rst_base_i;
        mask_q <= rst_mask_i;
        en_q   <= 1'b1;
        memo_q <= rst_mem_only_i;
      end
      match_q <= hit_d;
    end
  end

  assign match_o    = match_q;
  assign enable_o   = en_q;
  assign no_ready_o = nrdy_q;

endmodule : lbcs_window
`default_nettype wire

// ===== tb/lbcs_mem_model.sv
// Purpose: Memory and I/O device model on the far side of the local bus.
// Assumes: Address is carried on the muxed lines while the latch strobe is high.
// Notes:   Ready comes after a settable number of strobe cycles; idle data toggles.
`timescale 1ns/100ps
`default_nettype none
module lbcs_mem_model (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [15:0] ad_i,
  input  wire logic [3:0]  addr_hi_i,
  input  wire logic        addr_latch_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [7:0]  wait_i,
  output logic      [15:0] ad_o,
  output logic             ready_o
);
  logic [19:0] addr_q;
  logic [7:0]  cnt_q;
  logic [15:0] mem [int];

  // Latches the address, answers strobes after the wait count, stores writes.
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_q  <= 20'h00000;
      cnt_q   <= 8'h00;
      ready_o <= 1'b0;
      ad_o    <= 16'h5A5A;
    end else begin
      if (addr_latch_i) addr_q <= {addr_hi_i, ad_i};
      if (!rd_n_i || !wr_n_i) begin
        cnt_q   <= cnt_q + 8'h01;
        ready_o <= (cnt_q >= wait_i);
      end else begin
        cnt_q   <= 8'h00;
        ready_o <= 1'b0;
      end
      if (!wr_n_i && ready_o) mem[addr_q] = ad_i;
      // The device drives data only while read is asked; else the lines wander.
      if (!rd_n_i) ad_o <= mem.exists(addr_q) ? mem[addr_q] : addr_q[15:0] ^ 16'hA5A5;
      else ad_o <= ~ad_o;
    end
  end
endmodule : lbcs_mem_model
`default_nettype wire

// ===== tb/lbcs_top_tb.sv
// Purpose: Self-checking bench for the local bus control and region selects.
// Assumes: Wide variant; inputs change at the falling clock edge.
// Notes:   A queue-free model keeps expected memory in an associative array.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module lbcs_top_tb;
  import lbcs_pkg::*;
  logic ref_clk_i = 1'b0, reset_n_i = 1'b0, ext_n = 1'b1, req_valid_i = 1'b0;
  logic hold_i = 1'b0, cerr = 1'b0, creq = 1'b0, ready_i;
  logic [7:0] gen_n_rb;
  lbcs_req_t req_i = '0;
  lbcs_win_t win_i = '0;
  logic [7:0] port_wr_i = 8'h00, port_wdata_i = 8'h00, wait_i = 8'h00, gen_n, pv, irq_t;
  logic [15:0] ad_i, ad_o, rdata_o, wd, exp_mem [int];
  logic [3:0] addr_hi_o;
  logic rdy, done, ale, rd_n, wr_n, te_n, dir, up_n, lo_n, cp_n, irq_v, gnt, coe, aoe;
  logic lk_oe, lk_pu, pend, up_lo, lo_lo, g0_lo, cp_lo, rd_lo, wr_lo, irq_seen, bad_te;
  logic bad_hi, bad_wd, dir_s;
  logic [19:0] a;
  int errors = 0, checks_done = 0, seed = 32'h76BF, cyc_n;

  lbcs_top i_lbcs_top (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
    .external_reset_in_n_i(ext_n), .req_i(req_i), .req_valid_i(req_valid_i),
    .req_ready_o(rdy), .done_o(done), .rdata_o(rdata_o), .win_i(win_i),
    .port_wr_i(port_wr_i), .port_wdata_i(port_wdata_i), .port_readback_o(gen_n_rb),
    .ready_i(ready_i), .hold_i(hold_i), .coproc_error_i(cerr),
    .coproc_transfer_request_i(creq), .coproc_pending_o(pend), .irq_valid_o(irq_v),
    .irq_type_o(irq_t), .ad_i(ad_i), .ad_o(ad_o), .ad_oe_o(aoe), .addr_hi_o(addr_hi_o),
    .addr_hi_oe_o(), .addr_latch_o(ale), .read_strobe_n_o(rd_n), .write_strobe_n_o(wr_n),
    .ctrl_oe_o(coe), .high_byte_enable_n_o(), .refresh_strobe_n_o(),
    .transceiver_enable_n_o(te_n), .transceiver_direction_o(dir), .lock_n_o(),
    .lock_oe_o(lk_oe), .lock_pullup_o(lk_pu), .bus_grant_out_o(gnt),
    .coproc_select_n_o(cp_n), .upper_region_select_n_o(up_n),
    .lower_region_select_n_o(lo_n), .generic_region_select_n_o(gen_n));

  lbcs_mem_model i_lbcs_mem_model (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .ad_i(ad_o), .addr_hi_i(addr_hi_o), .addr_latch_i(ale), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .wait_i(wait_i), .ad_o(ad_i), .ready_o(ready_i));

  // Clock at 100 MHz.
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // Prints the verdict and ends the run.
  task automatic report_and_stop;
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // Expected read data: stored value, else the device's fill pattern.
  function automatic logic [15:0] exp_rd(input logic [19:0] ad);
    return exp_mem.exists(ad) ? exp_mem[ad] : ad[15:0] ^ 16'hA5A5;
  endfunction : exp_rd

  // Issues one request and watches the bus until done, recording what was seen.
  task automatic bus(input lbcs_cyc_t k, input logic [19:0] ad, input logic [15:0] d);
    {up_lo, lo_lo, g0_lo, cp_lo, rd_lo, wr_lo, irq_seen, bad_te, bad_hi, bad_wd} = '0;
    req_i       <= '{kind: k, addr: ad, byte_high: 1'b1, locked: 1'b0, boundary: 1'b1,
                     wdata: d};
    req_valid_i <= 1'b1;
    cyc_n = 0;
    // Ready is looked at once the request has settled, before the taking edge.
    #1;
    while (rdy !== 1'b1) begin
      @(negedge ref_clk_i);
      #1;
      if (++cyc_n > 20) begin errors++; report_and_stop(); end
    end
    @(negedge ref_clk_i);
    req_valid_i <= 1'b0;
    cyc_n = 0;
    while (done !== 1'b1) begin
      up_lo |= !up_n; lo_lo |= !lo_n; g0_lo |= !gen_n[0]; cp_lo |= !cp_n;
      if (irq_v === 1'b1) begin irq_seen = 1'b1; pv = irq_t; end
      if (!te_n && ale) bad_te = 1'b1;
      if (!rd_n || !wr_n) begin dir_s = dir; if (addr_hi_o !== 4'h0) bad_hi = 1'b1; end
      if (!rd_n) rd_lo = 1'b1;
      if (!wr_n) begin wr_lo = 1'b1; if (ad_o !== d) bad_wd = 1'b1; end
      @(negedge ref_clk_i);
      if (++cyc_n > 40) begin errors++; report_and_stop(); end
    end
  endtask : bus

  // Writes one region window for a single cycle.
  task automatic prog(input logic [3:0] ix, input logic [19:0] b, input logic [19:0] m,
                      input logic mo, input logic nr);
    win_i <= '{valid: 1'b1, index: ix, base: b, mask: m, enable: 1'b1, mem_only: mo,
               no_ready: nr};
    @(negedge ref_clk_i);
    win_i <= '0;
    @(negedge ref_clk_i);
  endtask : prog

  // Main sequence.
  initial begin
    repeat (3) @(negedge ref_clk_i);
    reset_n_i <= 1'b1;
    `CHK({up_n, lo_n, gen_n, gnt}, 11'h7FE)
    `CHK(lo_n, 1'b1)
    @(negedge ref_clk_i);
    // Random reads and writes inside the upper window, edges included.
    for (int i = 0; i < 10; i++) begin
      a = (i == 0) ? 20'hFFC00 : (i == 1) ? 20'hFFFFF : 20'hFFC00 | ($random(seed) & 20'h30F);
      wd = $random(seed);
      wait_i <= $random(seed) & 8'h03;
      if (i[0]) begin
        bus(LBCS_CYC_MEM_WR, a, wd);
        exp_mem[a] = wd;
        `CHK({wr_lo, bad_wd, dir_s}, 3'b101)
      end else begin
        bus(LBCS_CYC_MEM_RD, a, 16'h0000);
        `CHK(rdata_o, exp_rd(a))
        `CHK({rd_lo, dir_s}, 2'b10)
      end
      `CHK(up_lo, 1'b1)
      `CHK({bad_te, bad_hi}, 2'b00)
      `CHK(irq_seen, 1'b0)
    end
    wait_i <= 8'h06;
    bus(LBCS_CYC_MEM_RD, 20'hFFC04, 16'h0000);
    `CHK(cyc_n >= 8, 1'b1)
    wait_i <= 8'h00;
    bus(LBCS_CYC_MEM_RD, 20'hFFBFF, 16'h0000);
    `CHK(up_lo, 1'b0)
    bus(LBCS_CYC_MEM_RD, 20'h00010, 16'h0000);
    `CHK(lo_lo, 1'b0)
    prog(4'h1, 20'h00000, 20'hF0000, 1'b1, 1'b0);
    prog(4'h2, 20'h20000, 20'hF0000, 1'b0, 1'b1);
    bus(LBCS_CYC_MEM_RD, 20'h00010, 16'h0000);
    `CHK(lo_lo, 1'b1)
    bus(LBCS_CYC_IO_RD, 20'h00010, 16'h0000);
    `CHK(lo_lo, 1'b0)
    // Ready never comes here; the window ignores it.
    wait_i <= 8'hC8;
    bus(LBCS_CYC_IO_RD, 20'h20004, 16'h0000);
    `CHK(g0_lo, 1'b1)
    wait_i <= 8'h00;
    // Port mode on the generic pins that are not enabled.
    for (int i = 0; i < 3; i++) begin
      pv = $random(seed);
      port_wr_i    <= 8'hFE;
      port_wdata_i <= pv;
      @(negedge ref_clk_i);
      port_wr_i <= 8'h00;
      repeat (2) @(negedge ref_clk_i);
      `CHK(gen_n[7:1], pv[7:1])
      `CHK(gen_n_rb[7:1], pv[7:1])
    end
    cerr <= 1'b1;
    bus(LBCS_CYC_COPROC, 20'h000F8, 16'h0000);
    cerr <= 1'b0;
    `CHK({irq_seen, cp_lo}, 2'b11)
    `CHK(pv, COPROC_ERR_TYPE)
    `CHK(pend, 1'b0)
    creq <= 1'b1;
    @(negedge ref_clk_i);
    `CHK(pend, 1'b1)
    creq <= 1'b0;
    hold_i <= 1'b1;
    repeat (4) @(negedge ref_clk_i);
    `CHK({gnt, coe, aoe}, 3'b100)
    hold_i <= 1'b0;
    repeat (4) @(negedge ref_clk_i);
    `CHK(gnt, 1'b0)
    ext_n <= 1'b0;
    repeat (2) @(negedge ref_clk_i);
    `CHK({lk_pu, lk_oe}, 2'b10)
    ext_n <= 1'b1;
    report_and_stop();
  end
endmodule : lbcs_top_tb
`default_nettype wire
